//--- mmad_pkg.sv
package mmad_pkg;
    localparam int ADDR_W = 18;

    typedef enum logic [2:0] {
        MMAD_SINGLE    = 3'b001,
        MMAD_EXPANSION = 3'b010,
        MMAD_PROCESSOR = 3'b100
    } mmad_mode_type;

    typedef enum logic [1:0] {
        MMAD_AM_DIRECT = 2'h0,
        MMAD_AM_RAMS   = 2'h1,
        MMAD_AM_IOS    = 2'h2
    } mmad_amode_type;

    localparam logic [17:0] RAM_SHORT_BASE  = 18'h0_0000;
    localparam logic [17:0] SFR_BASE        = 18'h0_3F00;
    localparam logic [17:0] SFR_LAST        = 18'h0_3FFF;
    localparam logic [17:0] IRAM_BASE       = 18'h0_0000;
    localparam logic [17:0] IRAM_LAST       = 18'h0_27FF;
    localparam logic [17:0] IROM_BASE       = 18'h0_4000;
    localparam logic [17:0] IROM_LAST       = 18'h3_BFFF;
    localparam logic [17:0] XRAM_BASE       = 18'h0_2F00;
    localparam logic [17:0] XRAM_LAST       = 18'h0_3EFF;
    localparam logic [17:0] XROM_EXP_BASE   = 18'h2_0000;
    localparam logic [17:0] XROM_PROC_BASE  = 18'h0_4000;
    localparam logic [17:0] XROM_LAST       = 18'h3_FFFF;

    localparam int          EXT_ENABLE_BIT  = 4;
    localparam logic [7:0]  MEMORY_CONTROL_REGISTER_RESET    = 8'h00;
    localparam int          ADDR_GROUPS     = 3;
    localparam logic [2:0]  ADV_RESET       = 3'h0;
    // Address pins per enable group; groups cover A8..A17 upward
    localparam int          GROUP_LOW_BIT   = 8;
endpackage : mmad_pkg

//--- mmad_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module mmad_mode_ctrl
    import mmad_pkg::*;
(
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire logic          memory_mode_select_pin_i,
    input  wire logic          external_memory_enable_flag_i,
    output mmad_mode_type      mode_o
);
    logic          sel_meta;
    logic          sel_sync;
    logic          sampled;
    logic          proc_latched;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_meta <= 1'b0;
            sel_sync <= 1'b0;
        end else begin
            sel_meta <= memory_mode_select_pin_i;
            sel_sync <= sel_meta;
        end
    end

    // Pin caught once after the synchroniser fills, then frozen until reset
    logic [1:0] settle;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            settle       <= 2'h0;
            sampled      <= 1'b0;
            proc_latched <= 1'b0;
        end else if (!sampled) begin
            settle <= settle + 2'h1;
            if (settle == 2'h2) begin
                sampled      <= 1'b1;
                proc_latched <= sel_sync;
            end
        end
    end

    always_comb begin
        if (sampled && proc_latched)
            mode_o = MMAD_PROCESSOR;
        else if (sampled && external_memory_enable_flag_i)
            mode_o = MMAD_EXPANSION;
        else
            mode_o = MMAD_SINGLE;
    end

    a_mode_frozen: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $past(sampled) |-> proc_latched == $past(proc_latched))
        else $error("mode pin value changed after capture");
endmodule : mmad_mode_ctrl
`default_nettype wire

//--- mmad_ea_gen.sv
`timescale 1ns/100ps
`default_nettype none
module mmad_ea_gen
    import mmad_pkg::*;
(
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire mmad_amode_type amode_i,
    input  wire logic [17:0]   addr_i,
    input  wire logic [7:0]    offset_i,
    input  wire logic          second_byte_i,
    output logic [17:0]        ea_o
);
    logic [17:0] base;

    always_comb begin
        unique case (amode_i)
            MMAD_AM_RAMS: base = RAM_SHORT_BASE + {10'h000, offset_i};
            MMAD_AM_IOS:  base = SFR_BASE + {10'h000, offset_i};
            default:      base = addr_i;
        endcase
        // Upper byte of a word goes to the next byte, odd start allowed
        ea_o = base + {17'h0_0000, second_byte_i};
    end

    a_ios_offset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (amode_i == MMAD_AM_IOS && !second_byte_i) |-> ea_o == {10'h03F, offset_i})
        else $error("io short address wrong");
    a_rams_offset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (amode_i == MMAD_AM_RAMS && !second_byte_i) |-> ea_o == {10'h000, offset_i})
        else $error("ram short address wrong");
endmodule : mmad_ea_gen
`default_nettype wire

//--- mmad_decoder.sv
// Operation
// - Three memory modes from the mode pin and the external enable flag.
// - Single chip mode routes accesses only to internal ROM, internal RAM and the special function area.
// - External enable flag bit 4 in single chip mode selects expansion mode.
// - Address expansion register controls which address pins carry addresses in expansion mode; processor mode drives all of them.
// - Expansion mode keeps internal ROM and RAM while allowing external accesses.
// - Expansion mode external ROM window spans 0x20000 to 0x3FFFF.
// - Expansion and processor modes map external RAM 0x02F00 to 0x03EFF.
// - Mode pin high selects processor mode, fetching external ROM, ignoring internal.
// - Processor mode external ROM window spans 0x04000 to 0x3FFFF.
// - Internal RAM 0x00000 to 0x027FF, internal ROM 0x04000 to 0x3BFFF.
// - Special function area sits at 0x03F00 to 0x03FFF in every mode.
// - RAM short address is an 8-bit offset from zero.
// - I/O short address is the 8-bit offset added to 0x03F00.
// - Accesses are bytes; words are two successive bytes from any address.
// - Address pins not enabled for addresses remain general port pins.
`timescale 1ns/100ps
`default_nettype none
module mmad_decoder
    import mmad_pkg::*;
#(
    parameter logic [17:0] IRAM_TOP = IRAM_LAST,
    parameter logic [17:0] IROM_TOP = IROM_LAST
) (
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire logic          memory_mode_select_pin_i,
    input  wire logic [7:0]    memory_control_register_i,
    input  wire logic [2:0]    address_output_enable_bits_i,
    input  wire logic          acc_req_i,
    input  wire mmad_amode_type acc_amode_i,
    input  wire logic [17:0]   acc_addr_i,
    input  wire logic [7:0]    acc_offset_i,
    input  wire logic          acc_second_byte_i,
    input  wire logic [9:0]    port_out_i,
    output mmad_mode_type      mode_o,
    output logic [17:0]        ea_o,
    output logic               sel_iram_o,
    output logic               sel_irom_o,
    output logic               sel_sfr_o,
    output logic               sel_ext_o,
    output logic [9:0]         addr_pin_o
);
    mmad_mode_type mode;
    logic [17:0]   ea;
    logic          ext_mode;
    logic          in_sfr;
    logic          in_iram;
    logic          in_irom;
    logic          in_xram;
    logic          in_xrom;
    logic          next_iram;
    logic          next_irom;
    logic          next_sfr;
    logic          next_ext;
    logic [9:0]    next_pins;

    function automatic logic in_range(input logic [17:0] a,
                                      input logic [17:0] lo,
                                      input logic [17:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    mmad_mode_ctrl u_mode (
        .sys_clk_i                     (sys_clk_i),
        .rst_i                         (rst_i),
        .memory_mode_select_pin_i      (memory_mode_select_pin_i),
        .external_memory_enable_flag_i (memory_control_register_i[EXT_ENABLE_BIT]),
        .mode_o                        (mode)
    );

    mmad_ea_gen u_ea (
        .sys_clk_i     (sys_clk_i),
        .rst_i         (rst_i),
        .amode_i       (acc_amode_i),
        .addr_i        (acc_addr_i),
        .offset_i      (acc_offset_i),
        .second_byte_i (acc_second_byte_i),
        .ea_o          (ea)
    );

    assign ext_mode = (mode != MMAD_SINGLE);
    assign in_sfr   = in_range(ea, SFR_BASE, SFR_LAST);
    assign in_iram  = in_range(ea, IRAM_BASE, IRAM_TOP);
    assign in_irom  = in_range(ea, IROM_BASE, IROM_TOP);
    assign in_xram  = in_range(ea, XRAM_BASE, XRAM_LAST);
    always_comb begin
        unique case (mode)
            MMAD_EXPANSION: in_xrom = in_range(ea, XROM_EXP_BASE, XROM_LAST);
            MMAD_PROCESSOR: in_xrom = in_range(ea, XROM_PROC_BASE, XROM_LAST);
            default:        in_xrom = 1'b0;
        endcase
    end

    // SFR wins, then internal memory, then external windows
    always_comb begin
        next_iram = 1'b0;
        next_irom = 1'b0;
        next_sfr  = 1'b0;
        next_ext  = 1'b0;
        if (acc_req_i) begin
            if (in_sfr) begin
                next_sfr = 1'b1;
            end else if (in_iram) begin
                next_iram = 1'b1;
            end else if (in_irom && mode != MMAD_PROCESSOR) begin
                next_irom = 1'b1;
            end else if (ext_mode && (in_xram || in_xrom)) begin
                next_ext = 1'b1;
            end else if (ext_mode) begin
                // Everything unclaimed goes out in external modes
                next_ext = 1'b1;
            end
        end
    end

    // External ROM behind internal ROM in expansion mode is unreachable up to the internal ROM top
    always_comb begin
        next_pins = port_out_i;
        for (int g = 0; g < ADDR_GROUPS; g++) begin
            if (mode == MMAD_PROCESSOR ||
                (mode == MMAD_EXPANSION && address_output_enable_bits_i[g])) begin
                for (int b = 0; b < 4; b++) begin
                    if (g * 4 + b < 10)
                        next_pins[g * 4 + b] = ea[GROUP_LOW_BIT + g * 4 + b];
                end
            end
        end
        // Disabled groups keep the port data, behaviour
        if (mode == MMAD_SINGLE)
            next_pins = port_out_i;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_iram_o <= 1'b0;
            sel_irom_o <= 1'b0;
            sel_sfr_o  <= 1'b0;
            sel_ext_o  <= 1'b0;
        end else begin
            sel_iram_o <= next_iram;
            sel_irom_o <= next_irom;
            sel_sfr_o  <= next_sfr;
            sel_ext_o  <= next_ext;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ea_o       <= 18'h0_0000;
            addr_pin_o <= 10'h000;
        end else begin
            ea_o       <= ea;
            addr_pin_o <= next_pins;
        end
    end

    assign mode_o = mode;

    a_single_no_ext: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (mode == MMAD_SINGLE) ##1 (mode == MMAD_SINGLE) |-> !sel_ext_o)
        else $error("external select in single chip mode");
    a_proc_no_irom: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (mode == MMAD_PROCESSOR) |=> !sel_irom_o)
        else $error("internal rom used in processor mode");
    a_sfr_select: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (acc_req_i && ea >= 18'h0_3F00 && ea <= 18'h0_3FFF) |=> sel_sfr_o && !sel_ext_o)
        else $error("sfr area not selected");
    a_xram_window: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (acc_req_i && ext_mode && ea >= 18'h0_2F00 && ea <= 18'h0_3EFF && ea > IRAM_TOP)
        |=> sel_ext_o)
        else $error("external ram window not selected");
    a_exp_rom_win: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (acc_req_i && mode == MMAD_EXPANSION && ea > IROM_TOP) |=> sel_ext_o)
        else $error("expansion rom window not selected");
    a_proc_rom_win: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (acc_req_i && mode == MMAD_PROCESSOR && ea >= 18'h0_4000) |=> sel_ext_o)
        else $error("processor rom window not selected");
    a_exp_irom_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (acc_req_i && mode == MMAD_EXPANSION && ea >= 18'h0_4000 && ea <= IROM_TOP)
        |=> sel_irom_o)
        else $error("internal rom lost in expansion mode");
    a_one_select: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $onehot0({sel_iram_o, sel_irom_o, sel_sfr_o, sel_ext_o}))
        else $error("more than one target selected");
    a_port_pins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (mode == MMAD_EXPANSION && !address_output_enable_bits_i[0])
        |=> addr_pin_o[3:0] == $past(port_out_i[3:0]))
        else $error("disabled address pins not left to port");
endmodule : mmad_decoder
`default_nettype wire

//--- mmad_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module mmad_cpu_model (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       pin_level_i,
    input  wire logic       break_pin_i,
    input  wire logic       ext_enable_i,
    output logic            memory_mode_select_pin_o,
    output logic [7:0]      memory_control_register_o
);
    logic held_pin;

    // Strap level is captured only on clock edges while reset is asserted
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            held_pin <= pin_level_i;
        end
    end

    // A deliberate fault lets the pin follow the bench mid-run
    assign memory_mode_select_pin_o = break_pin_i ? pin_level_i : held_pin;

    // Software writes only the enable flag; wait fields stay clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            memory_control_register_o <= 8'h00;
        end else begin
            memory_control_register_o <= {3'h0, ext_enable_i, 4'h0};
        end
    end
endmodule : mmad_cpu_model
`default_nettype wire

//--- test_memory_mode_address_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_memory_mode_address_decoder;
    import mmad_pkg::*;
    logic           clk, rst, pin_level, break_pin, ext_en, req, second, mpin;
    logic [7:0]     memory_control_register, off;
    logic [2:0]     adv;
    logic [17:0]    addr, ea;
    logic [9:0]     port_out, pins;
    logic           s_iram, s_irom, s_sfr, s_ext;
    mmad_amode_type amode;
    mmad_mode_type  mode;
    int             bad_count = 0;
    int             tests_run = 0;

    mmad_cpu_model mmad_cpu_model_inst (.sys_clk_i(clk), .rst_i(rst), .pin_level_i(pin_level),
        .break_pin_i(break_pin), .ext_enable_i(ext_en), .memory_mode_select_pin_o(mpin),
        .memory_control_register_o(memory_control_register));

    mmad_decoder mmad_decoder_inst (.sys_clk_i(clk), .rst_i(rst), .memory_mode_select_pin_i(mpin),
        .memory_control_register_i(memory_control_register), .address_output_enable_bits_i(adv), .acc_req_i(req),
        .acc_amode_i(amode), .acc_addr_i(addr), .acc_offset_i(off), .acc_second_byte_i(second),
        .port_out_i(port_out), .mode_o(mode), .ea_o(ea), .sel_iram_o(s_iram), .sel_irom_o(s_irom),
        .sel_sfr_o(s_sfr), .sel_ext_o(s_ext), .addr_pin_o(pins));

    always #25 clk = ~clk;

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic restart(input logic pin);
        @(posedge clk);
        pin_level <= pin;
        ext_en    <= 1'b0;
        break_pin <= 1'b0;
        rst       <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK("reset mode", MMAD_SINGLE, mode)
        repeat (6) @(posedge clk);
        #1;
    endtask : restart

    // Selects are ordered iram, irom, sfr, ext
    task automatic acc(input mmad_amode_type am, input logic [17:0] a, input logic [7:0] o,
                       input logic sb, input logic [3:0] es, input logic [17:0] ee);
        @(posedge clk);
        req    <= 1'b1;
        amode  <= am;
        addr   <= a;
        off    <= o;
        second <= sb;
        @(posedge clk);
        #1;
        `CHK("select", es, {s_iram, s_irom, s_sfr, s_ext})
        `CHK("eff addr", ee, ea)
    endtask : acc

    task automatic run_single;
        restart(1'b0);
        `CHK("mode", MMAD_SINGLE, mode)
        acc(MMAD_AM_DIRECT, 18'h0_27FF, 8'h00, 1'b0, 4'b1000, 18'h0_27FF);
        acc(MMAD_AM_DIRECT, 18'h0_2800, 8'h00, 1'b0, 4'b0000, 18'h0_2800);
        acc(MMAD_AM_DIRECT, 18'h0_2F00, 8'h00, 1'b0, 4'b0000, 18'h0_2F00);
        acc(MMAD_AM_DIRECT, 18'h0_3FFF, 8'h00, 1'b0, 4'b0010, 18'h0_3FFF);
        acc(MMAD_AM_DIRECT, 18'h0_4000, 8'h00, 1'b0, 4'b0100, 18'h0_4000);
        acc(MMAD_AM_DIRECT, 18'h3_BFFF, 8'h00, 1'b0, 4'b0100, 18'h3_BFFF);
        acc(MMAD_AM_DIRECT, 18'h3_C000, 8'h00, 1'b0, 4'b0000, 18'h3_C000);
        acc(MMAD_AM_RAMS, 18'h0_0000, 8'hFF, 1'b0, 4'b1000, 18'h0_00FF);
        acc(MMAD_AM_IOS, 18'h0_0000, 8'h0E, 1'b0, 4'b0010, 18'h0_3F0E);
        acc(MMAD_AM_DIRECT, 18'h0_00FF, 8'h00, 1'b1, 4'b1000, 18'h0_0100);
        acc(MMAD_AM_DIRECT, 18'h0_27FF, 8'h00, 1'b1, 4'b0000, 18'h0_2800);
    endtask : run_single

    task automatic run_expansion;
        @(posedge clk);
        ext_en   <= 1'b1;
        adv      <= 3'b001;
        port_out <= 10'h3FF;
        repeat (3) @(posedge clk);
        #1;
        `CHK("mode", MMAD_EXPANSION, mode)
        acc(MMAD_AM_DIRECT, 18'h0_2F00, 8'h00, 1'b0, 4'b0001, 18'h0_2F00);
        acc(MMAD_AM_DIRECT, 18'h0_3EFF, 8'h00, 1'b0, 4'b0001, 18'h0_3EFF);
        acc(MMAD_AM_DIRECT, 18'h0_3F00, 8'h00, 1'b0, 4'b0010, 18'h0_3F00);
        acc(MMAD_AM_DIRECT, 18'h0_0010, 8'h00, 1'b0, 4'b1000, 18'h0_0010);
        acc(MMAD_AM_DIRECT, 18'h2_0000, 8'h00, 1'b0, 4'b0100, 18'h2_0000);
        acc(MMAD_AM_DIRECT, 18'h3_C5A0, 8'h00, 1'b0, 4'b0001, 18'h3_C5A0);
        `CHK("addr pins", 10'h3F5, pins)
        // Low group released so its pins must show the port data
        @(posedge clk);
        adv <= 3'b010;
        acc(MMAD_AM_DIRECT, 18'h3_C5A0, 8'h00, 1'b0, 4'b0001, 18'h3_C5A0);
        `CHK("addr pins", 10'h3CF, pins)
        acc(MMAD_AM_DIRECT, 18'h3_FFFF, 8'h00, 1'b0, 4'b0001, 18'h3_FFFF);
    endtask : run_expansion

    task automatic run_processor;
        @(posedge clk);
        adv      <= 3'b000;
        port_out <= 10'h000;
        restart(1'b1);
        `CHK("mode", MMAD_PROCESSOR, mode)
        acc(MMAD_AM_DIRECT, 18'h0_4000, 8'h00, 1'b0, 4'b0001, 18'h0_4000);
        acc(MMAD_AM_DIRECT, 18'h2_A512, 8'h00, 1'b0, 4'b0001, 18'h2_A512);
        `CHK("addr pins", 10'h2A5, pins)
        acc(MMAD_AM_DIRECT, 18'h0_3000, 8'h00, 1'b0, 4'b0001, 18'h0_3000);
        acc(MMAD_AM_DIRECT, 18'h0_0100, 8'h00, 1'b0, 4'b1000, 18'h0_0100);
        acc(MMAD_AM_IOS, 18'h0_0000, 8'h10, 1'b0, 4'b0010, 18'h0_3F10);
    endtask : run_processor

    // Pin moved after reset on purpose; the sampled mode must hold
    task automatic run_strap_hold;
        @(posedge clk);
        break_pin <= 1'b1;
        pin_level <= 1'b0;
        ext_en    <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        `CHK("held mode", MMAD_PROCESSOR, mode)
        restart(1'b0);
        @(posedge clk);
        break_pin <= 1'b1;
        pin_level <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        `CHK("held mode", MMAD_SINGLE, mode)
    endtask : run_strap_hold

    initial begin
        clk       = 1'b0;
        rst       = 1'b1;
        pin_level = 1'b0;
        break_pin = 1'b0;
        ext_en    = 1'b0;
        req       = 1'b0;
        amode     = MMAD_AM_DIRECT;
        addr      = 18'h0_0000;
        off       = 8'h00;
        second    = 1'b0;
        adv       = 3'b000;
        port_out  = 10'h000;
        run_single();
        run_expansion();
        run_processor();
        run_strap_hold();
        wrap_up();
    end

    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
endmodule : test_memory_mode_address_decoder
`default_nettype wire
